// ### pkg/nsrqhb_defines.svh
// nsrqhb_defines.svh: offsets, fields, reset values, coefficients, counts
// assumes: included by bare name from package and design files
// Functional notes
// - half-band filter runs only while the requantizer is enabled
// - bit 7 of halfband_mode_control picks low-pass or high-pass filtering
// - enabled half-band filter gives one output per two inputs
// - filter is 19-tap symmetric fixed-coefficient polyphase FIR
// - taps 2/16 are -47, 4/14 are 93, 6/12 are -194, odd zero
// - outer taps 25, taps 8/10 are 644, center tap 1024
// - high-pass mode negates the center tap only
// - low-pass keeps first zone, high-pass keeps second and third zones
// - enabled requantizer scales output down by 3.0 dB
// - each channel has its own requantizer enable and configuration
// - requantizer comes out of reset enabled
// - mode 000 in requant_profile_select selects the narrow 21% profile
// - narrow passband spans 21%, center 0.105 above lower edge
// - narrow tuning word is 0..58; software writes no more
// - mode 001 selects wide profile, 28% span, center 0.14 up
// - wide tuning word is 0..43; software writes no more
// - lower edge is tuning word times 0.005 of sample rate
`ifndef NSRQHB_DEFINES_SVH
`define NSRQHB_DEFINES_SVH
`define NSRQHB_ADDR_W        12
`define NSRQHB_DATA_W        14
`define NSRQHB_OFS_HB_CTRL   12'h41E
`define NSRQHB_OFS_PROFILE   12'h420
`define NSRQHB_OFS_TUNING    12'h422
`define NSRQHB_HB_HP_BIT     7
`define NSRQHB_HB_ACT_BIT    6
`define NSRQHB_HB_EN_BIT     0
`define NSRQHB_RQ_EN_BIT     0
`define NSRQHB_MODE_LSB      1
`define NSRQHB_MODE_MSB      3
`define NSRQHB_MODE_NARROW   3'h0
`define NSRQHB_MODE_WIDE     3'h1
`define NSRQHB_TW_MAX_NARROW 6'h3A
`define NSRQHB_TW_MAX_WIDE   6'h2B
`define NSRQHB_HALF_NARROW   7'h15
`define NSRQHB_HALF_WIDE     7'h1C
`define NSRQHB_QUARTER_IDX   7'h32
`define NSRQHB_RST_HB_EN     1'h0
`define NSRQHB_RST_HB_HP     1'h0
`define NSRQHB_RST_RQ_EN     1'h1
`define NSRQHB_RST_MODE      3'h0
`define NSRQHB_RST_TUNING    6'h00
`define NSRQHB_TAPS          19
`define NSRQHB_CENTER        9
`define NSRQHB_C0            12'h019
`define NSRQHB_C2            12'hFD1
`define NSRQHB_C4            12'h05D
`define NSRQHB_C6            12'hF3E
`define NSRQHB_C8            12'h284
`define NSRQHB_C9            12'h400
`define NSRQHB_HB_SHIFT      11
`define NSRQHB_SAMPLE_MAX    32'sh0000_1FFF
`define NSRQHB_SAMPLE_MIN    32'shFFFF_E000
`define NSRQHB_SCALE_3DB     32'h0000_00B5
`define NSRQHB_SCALE_SHIFT   8
`define NSRQHB_DROP_BITS     5
`define NSRQHB_FIFO_DEPTH    16
`define NSRQHB_FIFO_SLACK    6
`endif

// ### pkg/nsrqhb_pkg.sv
// nsrqhb_pkg: shared types of the requantizer and half-band datapath
// assumes: nsrqhb_defines.svh on the include path
`include "nsrqhb_defines.svh"
package nsrqhb_pkg;
   typedef logic signed [`NSRQHB_DATA_W-1:0] nsrqhb_sample_t;
   typedef enum logic {NSRQHB_NARROW, NSRQHB_WIDE} nsrqhb_profile_e;
endpackage : nsrqhb_pkg

// ### hw/nsrqhb_fifo.sv
// nsrqhb_fifo: synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ns
module nsrqhb_fifo
#(
   parameter int WIDTH = 14,
   parameter int DEPTH = 16
)
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH):0]          level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr_reg;
   logic [AW:0]      wr_ptr_next;
   logic [AW:0]      rd_ptr_reg;
   logic [AW:0]      rd_ptr_next;
   logic             do_wr;
   logic             do_rd;

   always_comb
   begin
      level       = wr_ptr_reg - rd_ptr_reg;
      in_ready    = (level != (AW+1)'(DEPTH));
      out_valid   = (level != '0);
      do_wr       = in_valid && in_ready;
      do_rd       = out_valid && out_ready;
      wr_ptr_next = wr_ptr_reg + (AW+1)'(do_wr);
      rd_ptr_next = rd_ptr_reg + (AW+1)'(do_rd);
      out_data    = mem[rd_ptr_reg[AW-1:0]];
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end
      else
      begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
      end
      if (do_wr)
      begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
endmodule : nsrqhb_fifo

// ### hw/nsrqhb_halfband.sv
// nsrqhb_halfband: 19-tap decimate-by-two half-band, low or high pass
// assumes: one sample per in_valid, same clock as the converter core
`timescale 1ns/1ns
`include "nsrqhb_defines.svh"
module nsrqhb_halfband
(
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   enable,
   input  wire logic                   high_pass,
   input  wire logic                   in_valid,
   input  wire nsrqhb_pkg::nsrqhb_sample_t in_data,
   output logic                        out_valid,
   output nsrqhb_pkg::nsrqhb_sample_t  out_data
);
   nsrqhb_pkg::nsrqhb_sample_t tap_reg  [`NSRQHB_TAPS];
   nsrqhb_pkg::nsrqhb_sample_t tap_next [`NSRQHB_TAPS];
   nsrqhb_pkg::nsrqhb_sample_t out_data_reg;
   nsrqhb_pkg::nsrqhb_sample_t out_data_next;
   logic                       out_valid_reg;
   logic                       out_valid_next;
   logic                       phase_reg;
   logic                       phase_next;
   logic signed [31:0]         acc;
   logic signed [31:0]         center_term;
   logic signed [31:0]         shifted;

   function automatic logic signed [11:0] pair_coef(input int k);
      case (k)
         0:       pair_coef = `NSRQHB_C0;
         2:       pair_coef = `NSRQHB_C2;
         4:       pair_coef = `NSRQHB_C4;
         6:       pair_coef = `NSRQHB_C6;
         8:       pair_coef = `NSRQHB_C8;
         default: pair_coef = '0;
      endcase
   endfunction : pair_coef

   genvar gi;
   generate
      for (gi = 0; gi < `NSRQHB_TAPS; gi++)
      begin : g_tap
         if (gi == 0)
         begin : g_head
            assign tap_next[gi] = in_valid ? in_data : tap_reg[gi];
         end
         else
         begin : g_body
            assign tap_next[gi] = in_valid ? tap_reg[gi-1] : tap_reg[gi];
         end
      end
   endgenerate

   always_comb
   begin
      acc = '0;
      // symmetric pairs on the even phase, odd taps are zero
      for (int k = 0; k < `NSRQHB_CENTER; k += 2)
      begin
         acc += 32'(pair_coef(k)) * (32'(tap_next[k])
                + 32'(tap_next[`NSRQHB_TAPS-1-k]));
      end
      center_term = 32'(tap_next[`NSRQHB_CENTER])
                    * 32'(signed'(`NSRQHB_C9));
      if (high_pass)
      begin
         center_term = -center_term;
      end
      shifted = (acc + center_term) >>> `NSRQHB_HB_SHIFT;
      if (shifted > `NSRQHB_SAMPLE_MAX)
      begin
         shifted = `NSRQHB_SAMPLE_MAX;
      end
      else if (shifted < `NSRQHB_SAMPLE_MIN)
      begin
         shifted = `NSRQHB_SAMPLE_MIN;
      end
      phase_next     = enable ? (phase_reg ^ in_valid) : 1'b0;
      out_valid_next = enable ? (in_valid && phase_reg) : in_valid;
      out_data_next  = out_data_reg;
      if (out_valid_next)
      begin
         out_data_next = enable ? shifted[`NSRQHB_DATA_W-1:0] : in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase_reg     <= 1'b0;
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
         for (int i = 0; i < `NSRQHB_TAPS; i++)
         begin
            tap_reg[i] <= '0;
         end
      end
      else
      begin
         phase_reg     <= phase_next;
         out_valid_reg <= out_valid_next;
         out_data_reg  <= out_data_next;
         tap_reg       <= tap_next;
      end
   end

   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;

   a_center_neg: assert property (@(posedge clk) disable iff (rst)
      (high_pass && tap_next[`NSRQHB_CENTER] > 0) |-> center_term < 0)
      else $error("center tap not negated in high-pass mode");
endmodule : nsrqhb_halfband

// ### hw/nsrqhb_top.sv
// nsrqhb_top: one channel of half-band decimation and noise shaping
// requantizer, with its serial-port registers and output fifo
// assumes: serial port, converter core and output path share clk
`timescale 1ns/1ns
`include "nsrqhb_defines.svh"
module nsrqhb_top
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic                       in_valid,
   input  wire nsrqhb_pkg::nsrqhb_sample_t in_data,
   output logic                            in_ready,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output nsrqhb_pkg::nsrqhb_sample_t      out_data,
   input  wire logic                       reg_sel,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   input  wire logic [`NSRQHB_ADDR_W-1:0]  reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   output logic [7:0]                      reg_rdata
);
   localparam int LVL_W = $clog2(`NSRQHB_FIFO_DEPTH) + 1;

   // register state
   logic                        hb_en_reg;
   logic                        hb_en_next;
   logic                        hb_hp_reg;
   logic                        hb_hp_next;
   logic                        rq_en_reg;
   logic                        rq_en_next;
   logic [2:0]                  mode_reg;
   logic [2:0]                  mode_next;
   logic [5:0]                  band_tuning_word_reg;
   logic [5:0]                  band_tuning_word_next;
   logic [7:0]                  reg_rdata_reg;
   logic [7:0]                  reg_rdata_next;
   logic                        wr_hb;
   logic                        wr_prof;
   logic                        wr_tune;
   // derived settings
   logic                        hb_active;
   nsrqhb_pkg::nsrqhb_profile_e profile;
   logic [5:0]                  tw_max;
   logic [5:0]                  tw_eff;
   logic [6:0]                  lower_idx;
   logic [6:0]                  center_idx;
   logic                        upper_band;
   // datapath
   logic                        acc_in;
   logic                        f_valid;
   nsrqhb_pkg::nsrqhb_sample_t  f_data;
   logic                        s_valid_reg;
   logic                        s_valid_next;
   nsrqhb_pkg::nsrqhb_sample_t  s_data_reg;
   nsrqhb_pkg::nsrqhb_sample_t  s_data_next;
   logic                        q_valid_reg;
   logic                        q_valid_next;
   nsrqhb_pkg::nsrqhb_sample_t  q_data_reg;
   nsrqhb_pkg::nsrqhb_sample_t  q_data_next;
   logic signed [5:0]           err_reg;
   logic signed [5:0]           err_next;
   logic signed [31:0]          prod;
   logic signed [31:0]          v;
   logic signed [31:0]          qv;
   logic signed [31:0]          sat_max;
   // fifo and output stage
   logic                        fifo_in_ready;
   logic                        fifo_out_valid;
   logic                        fifo_out_ready;
   nsrqhb_pkg::nsrqhb_sample_t  fifo_out_data;
   logic [LVL_W-1:0]            fifo_level;
   logic                        in_ready_reg;
   logic                        in_ready_next;
   logic                        out_valid_reg;
   logic                        out_valid_next;
   nsrqhb_pkg::nsrqhb_sample_t  out_data_reg;
   nsrqhb_pkg::nsrqhb_sample_t  out_data_next;

   // register writes and reads, one set per channel instance
   always_comb
   begin
      wr_hb   = reg_sel && reg_wr && reg_addr == `NSRQHB_OFS_HB_CTRL;
      wr_prof = reg_sel && reg_wr && reg_addr == `NSRQHB_OFS_PROFILE;
      wr_tune = reg_sel && reg_wr && reg_addr == `NSRQHB_OFS_TUNING;
      hb_en_next = wr_hb ? reg_wdata[`NSRQHB_HB_EN_BIT] : hb_en_reg;
      hb_hp_next = wr_hb ? reg_wdata[`NSRQHB_HB_HP_BIT] : hb_hp_reg;
      rq_en_next = wr_prof ? reg_wdata[`NSRQHB_RQ_EN_BIT] : rq_en_reg;
      mode_next  = wr_prof
                   ? reg_wdata[`NSRQHB_MODE_MSB:`NSRQHB_MODE_LSB]
                   : mode_reg;
      band_tuning_word_next = wr_tune ? reg_wdata[5:0]
                                      : band_tuning_word_reg;
      reg_rdata_next = reg_rdata_reg;
      if (reg_sel && reg_rd)
      begin
         reg_rdata_next = '0;
         unique case (reg_addr)
            `NSRQHB_OFS_HB_CTRL:
            begin
               reg_rdata_next[`NSRQHB_HB_HP_BIT]  = hb_hp_reg;
               reg_rdata_next[`NSRQHB_HB_ACT_BIT] = hb_active;
               reg_rdata_next[`NSRQHB_HB_EN_BIT]  = hb_en_reg;
            end
            `NSRQHB_OFS_PROFILE:
            begin
               reg_rdata_next[`NSRQHB_RQ_EN_BIT] = rq_en_reg;
               reg_rdata_next[`NSRQHB_MODE_MSB:`NSRQHB_MODE_LSB] = mode_reg;
            end
            `NSRQHB_OFS_TUNING:
            begin
               reg_rdata_next[5:0] = band_tuning_word_reg;
            end
            default:
            begin
               reg_rdata_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         hb_en_reg            <= `NSRQHB_RST_HB_EN;
         hb_hp_reg            <= `NSRQHB_RST_HB_HP;
         rq_en_reg            <= `NSRQHB_RST_RQ_EN;
         mode_reg             <= `NSRQHB_RST_MODE;
         band_tuning_word_reg <= `NSRQHB_RST_TUNING;
         reg_rdata_reg        <= '0;
      end
      else
      begin
         hb_en_reg            <= hb_en_next;
         hb_hp_reg            <= hb_hp_next;
         rq_en_reg            <= rq_en_next;
         mode_reg             <= mode_next;
         band_tuning_word_reg <= band_tuning_word_next;
         reg_rdata_reg        <= reg_rdata_next;
      end
   end

   // profile, tuning limit and passband placement
   always_comb
   begin
      hb_active = hb_en_reg && rq_en_reg;
      profile   = (mode_reg == `NSRQHB_MODE_WIDE)
                  ? nsrqhb_pkg::NSRQHB_WIDE
                  : nsrqhb_pkg::NSRQHB_NARROW;
      tw_max    = (profile == nsrqhb_pkg::NSRQHB_WIDE)
                  ? `NSRQHB_TW_MAX_WIDE : `NSRQHB_TW_MAX_NARROW;
      tw_eff    = (band_tuning_word_reg > tw_max)
                  ? tw_max : band_tuning_word_reg;
      lower_idx = {1'b0, tw_eff};
      center_idx = lower_idx + ((profile == nsrqhb_pkg::NSRQHB_WIDE)
                   ? `NSRQHB_HALF_WIDE : `NSRQHB_HALF_NARROW);
      upper_band = center_idx > `NSRQHB_QUARTER_IDX;
   end

   assign acc_in = in_valid && in_ready_reg;

   nsrqhb_halfband u_halfband
   (
      .clk       (clk),
      .rst       (rst),
      .enable    (hb_active),
      .high_pass (hb_hp_reg),
      .in_valid  (acc_in),
      .in_data   (in_data),
      .out_valid (f_valid),
      .out_data  (f_data)
   );

   // 3 dB scale, then requantize with first-order error feedback whose
   // noise notch sits at Nyquist when the band center is above a quarter, at DC otherwise
   always_comb
   begin
      sat_max = `NSRQHB_SAMPLE_MAX;
      prod = (32'(f_data) * signed'(`NSRQHB_SCALE_3DB))
             >>> `NSRQHB_SCALE_SHIFT;
      s_valid_next = f_valid;
      s_data_next  = s_data_reg;
      if (f_valid)
      begin
         s_data_next = rq_en_reg ? prod[`NSRQHB_DATA_W-1:0] : f_data;
      end
      v = upper_band ? 32'(s_data_reg) + 32'(err_reg)
                     : 32'(s_data_reg) - 32'(err_reg);
      if (v > sat_max)
      begin
         v = sat_max;
      end
      else if (v < -sat_max - 1)
      begin
         v = -sat_max - 1;
      end
      qv = (v >>> `NSRQHB_DROP_BITS) <<< `NSRQHB_DROP_BITS;
      q_valid_next = s_valid_reg;
      q_data_next  = q_data_reg;
      err_next     = err_reg;
      if (!rq_en_reg)
      begin
         err_next = '0;
      end
      if (s_valid_reg)
      begin
         q_data_next = rq_en_reg ? qv[`NSRQHB_DATA_W-1:0] : s_data_reg;
         err_next    = rq_en_reg ? 6'(qv - v) : 6'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_valid_reg <= 1'b0;
         s_data_reg  <= '0;
         q_valid_reg <= 1'b0;
         q_data_reg  <= '0;
         err_reg     <= '0;
      end
      else
      begin
         s_valid_reg <= s_valid_next;
         s_data_reg  <= s_data_next;
         q_valid_reg <= q_valid_next;
         q_data_reg  <= q_data_next;
         err_reg     <= err_next;
      end
   end

   nsrqhb_fifo
   #(
      .WIDTH (`NSRQHB_DATA_W),
      .DEPTH (`NSRQHB_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (q_valid_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (q_data_reg),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data),
      .level     (fifo_level)
   );

   // output register and input back-pressure
   always_comb
   begin
      fifo_out_ready = !out_valid_reg || out_ready;
      out_valid_next = out_valid_reg && !out_ready;
      out_data_next  = out_data_reg;
      if (fifo_out_ready && fifo_out_valid)
      begin
         out_valid_next = 1'b1;
         out_data_next  = fifo_out_data;
      end
      in_ready_next = fifo_in_ready && (fifo_level
                      < LVL_W'(`NSRQHB_FIFO_DEPTH - `NSRQHB_FIFO_SLACK));
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         out_valid_reg <= 1'b0;
         out_data_reg  <= '0;
         in_ready_reg  <= 1'b0;
      end
      else
      begin
         out_valid_reg <= out_valid_next;
         out_data_reg  <= out_data_next;
         in_ready_reg  <= in_ready_next;
      end
   end

   assign in_ready  = in_ready_reg;
   assign out_valid = out_valid_reg;
   assign out_data  = out_data_reg;
   assign reg_rdata = reg_rdata_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_hb_gate: assert property (
      (hb_en_reg && !rq_en_reg) |-> !hb_active)
      else $error("half-band active with requantizer off");
   a_hp_select: assert property (
      wr_hb |=> hb_hp_reg == $past(reg_wdata[`NSRQHB_HB_HP_BIT]))
      else $error("filter mode bit not taken");
   a_hb_decim: assert property (
      (hb_active && $past(hb_active) && f_valid) |-> !$past(f_valid))
      else $error("half-band not decimating by two");
   a_dec_pair: assert property (
      (hb_active && $past(hb_active) && acc_in ##1 acc_in && hb_active)
      |=> (f_valid ^ $past(f_valid)))
      else $error("decimated valid not on every second sample");
   a_scale_3db: assert property (
      (f_valid && rq_en_reg) |=> (32'($past(f_data))
      * signed'(`NSRQHB_SCALE_3DB) - (32'(s_data_reg)
      <<< `NSRQHB_SCALE_SHIFT)) inside {[0:255]})
      else $error("output not scaled down by 3 dB");
   a_reset_on: assert property (@(posedge clk)
      $past(rst) |-> rq_en_reg && mode_reg == `NSRQHB_RST_MODE)
      else $error("requantizer not enabled after reset");
   a_narrow_sel: assert property (
      (wr_prof && reg_wdata[`NSRQHB_MODE_MSB:`NSRQHB_MODE_LSB]
      == `NSRQHB_MODE_NARROW) |=> profile == nsrqhb_pkg::NSRQHB_NARROW
      && center_idx == lower_idx + `NSRQHB_HALF_NARROW)
      else $error("narrow profile not selected");
   a_wide_sel: assert property (
      (wr_prof && reg_wdata[`NSRQHB_MODE_MSB:`NSRQHB_MODE_LSB]
      == `NSRQHB_MODE_WIDE) |=> profile == nsrqhb_pkg::NSRQHB_WIDE
      && center_idx == lower_idx + `NSRQHB_HALF_WIDE)
      else $error("wide profile not selected");
   a_tw_narrow: assert property (
      profile == nsrqhb_pkg::NSRQHB_NARROW
      |-> tw_eff <= `NSRQHB_TW_MAX_NARROW)
      else $error("narrow tuning word out of range");
   a_tw_wide: assert property (
      profile == nsrqhb_pkg::NSRQHB_WIDE |-> tw_eff <= `NSRQHB_TW_MAX_WIDE)
      else $error("wide tuning word out of range");
   a_edge_step: assert property (
      (wr_tune && reg_wdata[5:0] <= `NSRQHB_TW_MAX_WIDE && !wr_prof)
      |=> lower_idx == 7'($past(reg_wdata[5:0])))
      else $error("lower edge does not follow tuning word");
   a_chan_sep: assert property (
      !reg_sel |=> $stable(rq_en_reg) && $stable(mode_reg))
      else $error("channel config changed while not addressed");
   a_fifo_safe: assert property (
      q_valid_reg |-> fifo_in_ready)
      else $error("fifo written while full");

   c_decim: cover property (hb_active && f_valid ##2 f_valid);
   c_highpass: cover property (hb_active && hb_hp_reg && f_valid);
   c_wide: cover property (profile == nsrqhb_pkg::NSRQHB_WIDE && q_valid_reg);
   c_stall: cover property (!in_ready_reg && in_valid);
endmodule : nsrqhb_top

// ### test/nsrqhb_partner.sv
// nsrqhb_partner: sample source and output sink around one channel
// assumes: drives on falling edges, design samples on rising edges
`timescale 1ns/1ns
module nsrqhb_partner
(
   input  wire logic                       clk,
   input  wire logic [15:0]                limit,
   input  wire nsrqhb_pkg::nsrqhb_sample_t val,
   input  wire logic [1:0]                 stall,
   input  wire logic                       in_ready,
   input  wire logic                       out_valid,
   input  wire nsrqhb_pkg::nsrqhb_sample_t out_data,
   output logic                            in_valid,
   output nsrqhb_pkg::nsrqhb_sample_t      in_data,
   output logic                            out_ready,
   output logic [15:0]                     n_sent,
   output logic [15:0]                     n_got,
   output nsrqhb_pkg::nsrqhb_sample_t      last_out
);
   logic ph = 1'b0;
   initial
   begin
      {in_valid, in_data, out_ready, n_sent, n_got, last_out} = '0;
   end
   // sample held until taken; idle line shows inverse of last value
   always @(negedge clk)
   begin
      ph        <= ~ph;
      in_valid  <= (n_sent < limit);
      in_data   <= (n_sent < limit) ? val : ~in_data;
      out_ready <= (stall == 2'h0) || (stall == 2'h1 && ph);
   end
   always @(posedge clk)
   begin
      if (in_valid && in_ready) n_sent <= n_sent + 16'h1;
      if (out_valid && out_ready)
      begin
         n_got    <= n_got + 16'h1;
         last_out <= out_data;
      end
   end
endmodule : nsrqhb_partner

// ### test/tb_nsrqhb_top.sv
// tb_nsrqhb_top: register and stream scenarios for one channel
// assumes: partner model feeds samples and drains the output
`timescale 1ns/1ns
module tb_nsrqhb_top;
   logic clk = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0;
   logic reg_rd = 1'b0, in_valid, in_ready, out_valid, out_ready;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic [15:0] limit = 16'h0000, n_sent, n_got, g, s;
   logic [1:0]  stall = 2'h0;
   nsrqhb_pkg::nsrqhb_sample_t val = 14'h0000;
   nsrqhb_pkg::nsrqhb_sample_t in_data, out_data, last_out;
   int n_fail = 0, n_compared = 0, cyc = 0;
   nsrqhb_top dut (.clk(clk), .rst(rst), .in_valid(in_valid),
      .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
      .out_ready(out_ready), .out_data(out_data), .reg_sel(reg_sel),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   nsrqhb_partner p (.clk(clk), .limit(limit), .val(val), .stall(stall),
      .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
      .in_valid(in_valid), .in_data(in_data), .out_ready(out_ready),
      .n_sent(n_sent), .n_got(n_got), .last_out(last_out));
   initial forever #4 clk = ~clk;
   task automatic finish_test;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         finish_test();
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
      @(negedge clk);
      {reg_sel, reg_wr} = 2'b00;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge clk);
      {reg_sel, reg_rd, reg_addr} = {2'b11, a};
      @(negedge clk);
      {reg_sel, reg_rd} = 2'b00;
      check({8'h00, reg_rdata}, {8'h00, exp});
   endtask : rd
   task automatic run(input logic [15:0] n, input logic [13:0] v,
                      input logic [1:0] st);
      @(negedge clk);
      {g, s, val, stall} = {n_got, n_sent, v, st};
      limit = n_sent + n;
      repeat (80) @(negedge clk);
   endtask : run
   task automatic t_regs;
      rd(12'h41E, 8'h00);
      rd(12'h420, 8'h01);
      rd(12'h422, 8'h00);
      rd(12'h000, 8'h00);
      wr(12'h420, 8'h03);
      rd(12'h420, 8'h03);
      wr(12'h422, 8'h2B);
      rd(12'h422, 8'h2B);
      wr(12'h420, 8'h01);
      wr(12'h422, 8'h3A);
      rd(12'h422, 8'h3A);
      wr(12'h422, 8'h00);
      wr(12'h41E, 8'h81);
      rd(12'h41E, 8'hC1);
      wr(12'h420, 8'h00);
      rd(12'h41E, 8'h81);
   endtask : t_regs
   task automatic t_stream;
      run(16'd8, 14'h0100, 2'h0);
      check(n_got - g, 16'd8);
      check(last_out, 16'h0100);
      wr(12'h420, 8'h01);
      wr(12'h41E, 8'h00);
      wr(12'h422, 8'h3A);
      run(16'd8, 14'h0FA0, 2'h0);
      check(last_out >= 2752 && last_out <= 2944, 16'h1);
      wr(12'h41E, 8'h01);
      run(16'd40, 14'h0FA0, 2'h1);
      check(n_got - g, 16'd20);
      check(last_out >= 2752 && last_out <= 2944, 16'h1);
      wr(12'h41E, 8'h81);
      run(16'd40, 14'h0FA0, 2'h0);
      check(last_out >= -64 && last_out <= 64, 16'h1);
   endtask : t_stream
   task automatic t_fifo;
      wr(12'h41E, 8'h00);
      wr(12'h420, 8'h00);
      run(16'd40, 14'h0055, 2'h2);
      check(in_ready, 1'b0);
      check(n_got - g, 16'd0);
      stall = 2'h1;
      repeat (120) @(negedge clk);
      check(n_got - g, 16'd40);
      check(n_sent - s, 16'd40);
      check(last_out, 16'h0055);
   endtask : t_fifo
   initial
   begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      t_regs();
      t_stream();
      t_fifo();
      finish_test();
   end
endmodule : tb_nsrqhb_top
